// ==== common/gpio_cmd_defines.vh ====
// Constants shared by the GPIO command interpreter: commands, frame sizes, registers, resets.
`ifndef GPIO_CMD_DEFINES_VH
`define GPIO_CMD_DEFINES_VH

`define CMD_GET_FUNC 8'h10
`define CMD_GET_DIR 8'h11
`define CMD_GET_POL 8'h12
`define CMD_GET_STATE 8'h13
`define CMD_SET_DIR 8'h19
`define CMD_SET_POL 8'h1a
`define CMD_SET_STATE 8'h1b
`define RESP_INVALID 8'hff

`define CMD_FRAME_BYTES 4'h9
`define CMD_LAST_IDX 4'h8
`define RESP_OK_BYTES 3'h5
`define RESP_ERR_BYTES 3'h1

`define REG_FUNC 8'h00
`define REG_BOOT_DIR 8'h04
`define REG_BOOT_POL 8'h08
`define REG_CTRL 8'h0c
`define REG_STATUS 8'h10

`define CTRL_PORT_DISABLE 0
`define CTRL_RELOAD 1

`define STATUS_DIR_LSB 0
`define STATUS_POL_LSB 8
`define STATUS_STATE_LSB 16
`define STATUS_LEVEL_LSB 24

`define RST_FUNC 1'b1
`define RST_DIR 1'b0
`define RST_POL 1'b1
`define RST_STATE 1'b0

`endif

// ==== hdl/gpio_command_protocol.v ====
// Binary GPIO command interpreter with configuration registers and pin drivers.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "gpio_cmd_defines.vh"
// What this block does
// - Three configurable pins, each independently usable as general purpose I/O.
// - After reset every pin is a general purpose input, active low.
// - Parameters are 32-bit little-endian bitmaps, pin 0 in bit 0 of byte one.
// - Non-GPIO pins read as zero in command answers and are ignored by set commands.
// - A command is nine bytes: code, then two four-byte parameters.
// - A valid command answers five bytes: echoed code plus a four-byte bitmap.
// - An invalid command answers the single byte 0xff.
// - Code 0x10 returns the function bitmap, 1 meaning user I/O.
// - Code 0x11 returns directions, 1 output, 0 input.
// - Code 0x12 returns polarities, 1 active low, 0 active high.
// - Code 0x13 returns logical states, 1 active, 0 inactive.
// - Code 0x19 loads masked directions from parameter two.
// - Code 0x1a loads masked polarities from parameter two.
// - Code 0x1b loads masked states from parameter two.
// - A set answer carries the whole attribute bitmap after the update.
// - No command changes functions; such codes get the invalid answer.
// - Set values are volatile; reset or reload restores the boot configuration.
// - Pin level is state combined with polarity; active low drives low when active.
// - Boot direction and polarity come from configuration registers.
// - Commands arrive on one byte stream; a setting makes it drain and drop received bytes, pins stay driven.
module gpio_command_protocol #(
    parameter NUM_PINS = 3
) (
    input wire core_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_start,
    output wire rx_ready,
    output wire tx_valid,
    output wire [7:0] tx_data,
    output wire tx_last,
    input wire tx_ready,
    input wire [NUM_PINS-1:0] pin_in,
    output wire [NUM_PINS-1:0] pin_out,
    output wire [NUM_PINS-1:0] pin_oe
);

    localparam S_RX = 2'b00;
    localparam S_EXEC = 2'b01;
    localparam S_RESP = 2'b10;
    localparam S_TX = 2'b11;
    localparam PAD = 32 - NUM_PINS;
    localparam SPAD = 8 - NUM_PINS;

    // Bits beyond the fitted pins are dropped on writes and return zero.
    function [NUM_PINS-1:0] merge;
        input [NUM_PINS-1:0] old_val;
        input [NUM_PINS-1:0] mask;
        input [NUM_PINS-1:0] new_val;
        begin
            merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    function is_known;
        input [7:0] code;
        begin
            case (code)
                `CMD_GET_FUNC, `CMD_GET_DIR, `CMD_GET_POL, `CMD_GET_STATE,
                `CMD_SET_DIR, `CMD_SET_POL, `CMD_SET_STATE: is_known = 1'b1;
                default: is_known = 1'b0;
            endcase
        end
    endfunction

    function [31:0] widen;
        input [NUM_PINS-1:0] bits;
        begin
            widen = {{PAD{1'b0}}, bits};
        end
    endfunction

    function [7:0] widen8;
        input [NUM_PINS-1:0] bits;
        begin
            widen8 = {{SPAD{1'b0}}, bits};
        end
    endfunction

    reg [NUM_PINS-1:0] func_reg;
    reg [NUM_PINS-1:0] boot_dir_reg;
    reg [NUM_PINS-1:0] boot_pol_reg;
    reg port_disable_reg;
    reg [NUM_PINS-1:0] dir_reg;
    reg [NUM_PINS-1:0] pol_reg;
    reg [NUM_PINS-1:0] state_reg;
    reg [1:0] fsm_reg;
    reg [3:0] byte_cnt_reg;
    reg [7:0] cmd_reg;
    reg [31:0] p1_reg;
    reg [31:0] p2_reg;
    reg [39:0] resp_reg;
    reg [2:0] tx_left_reg;

    wire reload = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_RELOAD];
    wire [3:0] byte_idx = rx_start ? 4'h0 : byte_cnt_reg;
    wire rx_take = rx_valid && (fsm_reg == S_RX);
    wire tx_take = tx_valid && tx_ready;
    wire [NUM_PINS-1:0] set_mask = p1_reg[NUM_PINS-1:0] & func_reg;
    wire [NUM_PINS-1:0] set_val = p2_reg[NUM_PINS-1:0];
    wire [NUM_PINS-1:0] input_active = pin_in ^ pol_reg;
    wire [NUM_PINS-1:0] state_view = ((dir_reg & state_reg) | (~dir_reg & input_active))
        & func_reg;
    wire cmd_ok = is_known(cmd_reg);

    // Dedicated pins are left undriven so their own function owns them.
    assign pin_oe = dir_reg & func_reg;
    assign pin_out = (state_reg ^ pol_reg) & pin_oe;

    assign rx_ready = (fsm_reg == S_RX);
    assign tx_valid = (fsm_reg == S_TX);
    assign tx_data = resp_reg[7:0];
    assign tx_last = (fsm_reg == S_TX) && (tx_left_reg == 3'h1);

    // Configuration registers and the read port.
    always @(posedge core_clk) begin
        if (reset) begin
            func_reg <= {NUM_PINS{`RST_FUNC}};
            boot_dir_reg <= {NUM_PINS{`RST_DIR}};
            boot_pol_reg <= {NUM_PINS{`RST_POL}};
            port_disable_reg <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `REG_FUNC: func_reg <= reg_wdata[NUM_PINS-1:0];
                    `REG_BOOT_DIR: boot_dir_reg <= reg_wdata[NUM_PINS-1:0];
                    `REG_BOOT_POL: boot_pol_reg <= reg_wdata[NUM_PINS-1:0];
                    `REG_CTRL: port_disable_reg <= reg_wdata[`CTRL_PORT_DISABLE];
                    default: ;
                endcase
            end
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_FUNC: reg_rdata <= widen(func_reg);
                    `REG_BOOT_DIR: reg_rdata <= widen(boot_dir_reg);
                    `REG_BOOT_POL: reg_rdata <= widen(boot_pol_reg);
                    `REG_CTRL: reg_rdata <= {31'h00000000, port_disable_reg};
                    `REG_STATUS: reg_rdata <= {widen8(pin_in), widen8(state_view),
                        widen8(pol_reg), widen8(dir_reg)};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Live pin attributes; a reload takes priority over a set in the same cycle.
    always @(posedge core_clk) begin
        if (reset) begin
            dir_reg <= {NUM_PINS{`RST_DIR}};
            pol_reg <= {NUM_PINS{`RST_POL}};
            state_reg <= {NUM_PINS{`RST_STATE}};
        end else if (reload) begin
            dir_reg <= boot_dir_reg;
            pol_reg <= boot_pol_reg;
            state_reg <= {NUM_PINS{`RST_STATE}};
        end else if (fsm_reg == S_EXEC) begin
            case (cmd_reg)
                `CMD_SET_DIR: dir_reg <= merge(dir_reg, set_mask, set_val);
                `CMD_SET_POL: pol_reg <= merge(pol_reg, set_mask, set_val);
                `CMD_SET_STATE: state_reg <= merge(state_reg, set_mask, set_val);
                default: ;
            endcase
        end
    end

    // Command collection, execution and answer.
    always @(posedge core_clk) begin
        if (reset) begin
            fsm_reg <= S_RX;
            byte_cnt_reg <= 4'h0;
            cmd_reg <= 8'h00;
            p1_reg <= 32'h00000000;
            p2_reg <= 32'h00000000;
            resp_reg <= 40'h0000000000;
            tx_left_reg <= 3'h0;
        end else begin
            case (fsm_reg)
                S_RX: begin
                    if (port_disable_reg) begin
                        // Bytes are drained and dropped so the link never jams.
                        byte_cnt_reg <= 4'h0;
                    end else if (rx_take) begin
                        if (byte_idx == 4'h0) begin
                            cmd_reg <= rx_data;
                        end else if (byte_idx < 4'h5) begin
                            p1_reg <= {rx_data, p1_reg[31:8]};
                        end else begin
                            p2_reg <= {rx_data, p2_reg[31:8]};
                        end
                        if (byte_idx == `CMD_LAST_IDX) begin
                            byte_cnt_reg <= 4'h0;
                            fsm_reg <= S_EXEC;
                        end else begin
                            byte_cnt_reg <= byte_idx + 4'h1;
                        end
                    end
                end
                S_EXEC: begin
                    fsm_reg <= S_RESP;
                end
                S_RESP: begin
                    // Built a cycle after execution so set answers show the new bitmap.
                    fsm_reg <= S_TX;
                    tx_left_reg <= cmd_ok ? `RESP_OK_BYTES : `RESP_ERR_BYTES;
                    case (cmd_reg)
                        `CMD_GET_FUNC: resp_reg <= {widen(func_reg), cmd_reg};
                        `CMD_GET_DIR, `CMD_SET_DIR:
                            resp_reg <= {widen(dir_reg & func_reg), cmd_reg};
                        `CMD_GET_POL, `CMD_SET_POL:
                            resp_reg <= {widen(pol_reg & func_reg), cmd_reg};
                        `CMD_GET_STATE, `CMD_SET_STATE:
                            resp_reg <= {widen(state_view), cmd_reg};
                        default: resp_reg <= {32'h00000000, `RESP_INVALID};
                    endcase
                end
                S_TX: begin
                    if (tx_take) begin
                        resp_reg <= {8'h00, resp_reg[39:8]};
                        tx_left_reg <= tx_left_reg - 3'h1;
                        if (tx_left_reg == 3'h1) begin
                            fsm_reg <= S_RX;
                        end
                    end
                end
                default: fsm_reg <= S_RX;
            endcase
        end
    end

endmodule

// ==== sim/gpio_command_protocol_monitor.sv ====
// Port assertions for the GPIO command interpreter.
`timescale 1ns/1ns
module gpio_command_protocol_monitor #(parameter NUM_PINS = 3) (
    input wire core_clk,
    input wire reset,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire rx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_ready,
    input wire [NUM_PINS-1:0] pin_out,
    input wire [NUM_PINS-1:0] pin_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // The reset check must run while reset is high, so it opts out of the default.
    property p_rst; disable iff (1'b0) reset |=> pin_oe == 0 && !tx_valid && rx_ready; endproperty
    property p_drv; (pin_out & ~pin_oe) == 0; endproperty
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    property p_busy; tx_valid |-> !rx_ready; endproperty
    property p_err; tx_valid && tx_data == 8'hff |-> tx_last; endproperty
    // With three pins the top bitmap byte is always zero.
    property p_top; tx_valid && tx_last && tx_data != 8'hff |-> tx_data == 8'h00; endproperty
    property p_lat; $fell(rx_ready) |-> !tx_valid ##1 !tx_valid ##1 tx_valid; endproperty
    property p_next; tx_valid && tx_ready && tx_last |=> rx_ready && !tx_valid; endproperty
    property p_rd; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_drv: assert property (p_drv) else $error("undriven pin high");
    a_hold: assert property (p_hold) else $error("answer byte moved");
    a_busy: assert property (p_busy) else $error("takes bytes while answering");
    a_err: assert property (p_err) else $error("error answer too long");
    a_top: assert property (p_top) else $error("top bitmap byte set");
    a_lat: assert property (p_lat) else $error("answer latency wrong");
    a_next: assert property (p_next) else $error("not ready after answer");
    a_rd: assert property (p_rd) else $error("read data outside slot");
    c_err: cover property (tx_valid && tx_data == 8'hff);
    c_stall: cover property (tx_valid && !tx_ready);
    c_out: cover property (pin_oe != 0);
endmodule
bind gpio_command_protocol gpio_command_protocol_monitor #(.NUM_PINS(NUM_PINS)) u_mon (
    .core_clk(core_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .pin_out(pin_out), .pin_oe(pin_oe));

// ==== sim/gpio_command_protocol_test.sv ====
// Self-checking bench for the GPIO command interpreter.
`timescale 1ns/1ns
module gpio_command_protocol_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] pin_in = 3'b100;
    wire [31:0] reg_rdata;
    wire rx_valid, rx_start, rx_ready, tx_valid, tx_last, tx_ready;
    wire [7:0] rx_data, tx_data;
    wire [2:0] pin_out, pin_oe;
    int n_fail = 0;
    int check_count = 0;
    always #2 core_clk = ~core_clk;
    gpio_command_protocol u_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_start(rx_start), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    gpio_host_model u_host (.core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_start(rx_start), .tx_ready(tx_ready));
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input [7:0] c, input [31:0] p1, input [31:0] p2, input bit slow,
                       input [39:0] exp, input int en);
        logic [39:0] r;
        int n;
        u_host.xfer(c, p1, p2, slow, r, n);
        chk(r, exp);
        chk(40'(n), 40'(en));
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Read data stand only in this cycle, so look mid-cycle.
        @(negedge core_clk);
        chk({8'h0, reg_rdata}, {8'h0, e});
    endtask
    task automatic t_boot;
        rd(8'h00, 32'h7);
        rd(8'h08, 32'h7);
        cmd(8'h10, 32'hffffffff, 32'h0, 1'b0, {32'h7, 8'h10}, 5);
        cmd(8'h11, 32'h0, 32'h0, 1'b0, {32'h0, 8'h11}, 5);
        cmd(8'h12, 32'h0, 32'h0, 1'b1, {32'h7, 8'h12}, 5);
        chk({37'h0, pin_oe}, 40'h0);
    endtask
    task automatic t_bad;
        logic [7:0] codes [6] = '{8'h00, 8'h14, 8'h18, 8'h1c, 8'h20, 8'hff};
        foreach (codes[i]) cmd(codes[i], 32'h7, 32'h7, 1'b0, {32'h0, 8'hff}, 1);
        cmd(8'h13, 32'h0, 32'h0, 1'b0, {32'h3, 8'h13}, 5);
    endtask
    task automatic t_set;
        cmd(8'h19, 32'hfffffff3, 32'h1, 1'b1, {32'h1, 8'h19}, 5);
        chk({37'h0, pin_oe}, 40'h1);
        cmd(8'h1a, 32'h1, 32'h6, 1'b0, {32'h6, 8'h1a}, 5);
        cmd(8'h1b, 32'h5, 32'h5, 1'b1, {32'h3, 8'h1b}, 5);
        chk({37'h0, pin_out}, 40'h1);
        cmd(8'h1a, 32'h1, 32'h1, 1'b0, {32'h7, 8'h1a}, 5);
        chk({37'h0, pin_out}, 40'h0);
        rd(8'h10, 32'h04030701);
        pin_in <= 3'b000;
        cmd(8'h13, 32'h0, 32'h0, 1'b0, {32'h7, 8'h13}, 5);
    endtask
    task automatic t_func;
        wr(8'h00, 32'h6);
        cmd(8'h10, 32'h0, 32'h0, 1'b0, {32'h6, 8'h10}, 5);
        cmd(8'h19, 32'h7, 32'h7, 1'b0, {32'h6, 8'h19}, 5);
        chk({37'h0, pin_oe}, 40'h6);
    endtask
    task automatic t_reload;
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'h2);
        cmd(8'h11, 32'h0, 32'h0, 1'b0, {32'h2, 8'h11}, 5);
        cmd(8'h12, 32'h0, 32'h0, 1'b1, {32'h0, 8'h12}, 5);
    endtask
    task automatic t_off;
        wr(8'h0c, 32'h1);
        cmd(8'h10, 32'h0, 32'h0, 1'b0, 40'h0, 0);
        wr(8'h0c, 32'h0);
        cmd(8'h10, 32'h0, 32'h0, 1'b0, {32'h6, 8'h10}, 5);
        rd(8'h20, 32'h0);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_boot;
        t_bad;
        t_set;
        t_func;
        t_reload;
        t_off;
        stop_test;
    end
    // About twenty commands of some twenty cycles each fit well inside this span.
    initial begin
        #40000;
        n_fail++;
        stop_test;
    end
endmodule

// ==== sim/gpio_host_model.sv ====
// Host model: sends nine-byte commands and collects the answer bytes.
`timescale 1ns/1ns
module gpio_host_model (
    input wire core_clk,
    input wire rx_ready,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_start = 1'b0,
    output logic tx_ready = 1'b0
);
    task automatic xfer(input [7:0] c, input [31:0] p1, input [31:0] p2, input bit slow,
                        output logic [39:0] resp, output int n);
        logic [71:0] f;
        logic take;
        logic last;
        logic [7:0] b;
        f = {p2, p1, c};
        resp = 40'h0;
        n = 0;
        @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            rx_valid <= 1'b1;
            rx_start <= (i == 0);
            rx_data <= f[8*i +: 8];
            // The device collects while this model sends, so every edge takes a byte.
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        rx_start <= 1'b0;
        // A released data line must not keep showing the last byte.
        rx_data <= ~f[71:64];
        for (int k = 0; k < 40; k++) begin
            tx_ready <= !slow || k[0];
            // Sample mid-cycle what the coming edge will hand over.
            @(negedge core_clk);
            take = tx_valid && tx_ready;
            b = tx_data;
            last = tx_last;
            @(posedge core_clk);
            if (take) begin
                resp[8*n +: 8] = b;
                n++;
                if (last || n == 5) break;
            end
        end
        tx_ready <= 1'b0;
    endtask
endmodule
